/* verilog/hbhr_pkg.sv */
// Purpose: Constants and types for the host boot handshake registers
// Assumes: 32-bit register access, byte addresses as printed
// Notes: Shared by the register bank and its bench
package hbhr_pkg;
  localparam logic [31:0] HBHR_START_ADDR_OFS = 32'h01c40008;
  localparam logic [31:0] HBHR_BOOT_CMPL_OFS = 32'h01c4000c;
  localparam logic [31:0] HBHR_ROM_START_RST = 32'h00100000;
  localparam logic [31:0] HBHR_EXT_START_RST = 32'h42000000;
  localparam int HBHR_ERR_LSB = 16;
  localparam int HBHR_ERR_W = 4;
  localparam int HBHR_DONE_BIT = 0;
  localparam int HBHR_IGN_W = 10;
  localparam logic [3:0] HBHR_ERR_RST = 4'h0;
  localparam logic HBHR_DONE_RST = 1'b0;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [31:0] addr;
    logic [31:0] wdata;
  } hbhr_req_s;
endpackage

/* verilog/hbhr_regs.sv */
// Purpose: Boot completion and processor start address registers
// Assumes: Host and firmware accesses arrive already merged on one port
// Notes: Boot mode select pin is synchronised, then sampled just after reset release
`timescale 1ns/10ps
module hbhr_regs
  import hbhr_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire hbhr_req_s req,
  output logic [31:0] rdata,
  output logic rvalid,
  input wire logic boot_from_ext_mem,
  output logic [31:0] cpu_fetch_addr,
  output logic branch_go,
  output logic host_load_done_flag
);

  logic mode_s1_q;
  logic mode_s2_q;
  logic strap_taken_q;
  logic [31:0] start_q;
  logic [31:0] start_d;
  logic [3:0] err_q;
  logic [3:0] err_d;
  logic done_q;
  logic done_d;
  logic done_seen_q;
  logic [31:0] rdata_q;
  logic rvalid_q;

  wire hit_start = req.addr == HBHR_START_ADDR_OFS;
  wire hit_cmpl = req.addr == HBHR_BOOT_CMPL_OFS;
  wire wr_start = req.wr && hit_start;
  wire wr_cmpl = req.wr && hit_cmpl;
  wire [31:0] cmpl_view = {12'h000, err_q, 15'h0000, done_q};
  wire [31:0] strap_start = mode_s2_q ? HBHR_EXT_START_RST : HBHR_ROM_START_RST;
  wire [31:0] rd_mux = hit_start ? start_q : (hit_cmpl ? cmpl_view : 32'h00000000);

  // Reserved bits of the write data are dropped whatever the host sends
  assign err_d = wr_cmpl ? req.wdata[HBHR_ERR_LSB +: HBHR_ERR_W] : err_q;
  assign done_d = done_q | (wr_cmpl & req.wdata[HBHR_DONE_BIT]);
  // A host write in the strap cycle wins over the strap default
  assign start_d = wr_start ? req.wdata : (strap_taken_q ? start_q : strap_start);

  // No reset here: the pin must already be settled through reset for the strap to see it
  always_ff @(posedge clk) begin
    mode_s1_q <= boot_from_ext_mem;
    mode_s2_q <= mode_s1_q;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strap_taken_q <= 1'b0;
      start_q <= HBHR_ROM_START_RST;
      err_q <= HBHR_ERR_RST;
      done_q <= HBHR_DONE_RST;
      done_seen_q <= 1'b0;
    end else begin
      strap_taken_q <= 1'b1;
      start_q <= start_d;
      err_q <= err_d;
      done_q <= done_d;
      done_seen_q <= done_q;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 32'h00000000;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= req.rd ? rd_mux : rdata_q;
      rvalid_q <= req.rd;
    end
  end

  assign rdata = rdata_q;
  assign rvalid = rvalid_q;
  assign host_load_done_flag = done_q;
  assign cpu_fetch_addr = {start_q[31:HBHR_IGN_W], 10'h000};
  assign branch_go = done_q & ~done_seen_q;

  a_done_sticky: assert property (@(posedge clk) disable iff (!rstn)
    $past(done_q) |-> done_q) else $error("done flag dropped");
  a_done_set: assert property (@(posedge clk) disable iff (!rstn)
    wr_cmpl && req.wdata[0] |=> done_q) else $error("done flag not set");
  a_branch_pulse: assert property (@(posedge clk) disable iff (!rstn)
    branch_go |=> !branch_go) else $error("branch not single pulse");
  a_branch_cause: assert property (@(posedge clk) disable iff (!rstn)
    $rose(done_q) |-> branch_go) else $error("branch missed");
  a_fetch_low: assert property (@(posedge clk) disable iff (!rstn)
    cpu_fetch_addr[9:0] == 10'h000 && cpu_fetch_addr[31:10] == start_q[31:10])
    else $error("fetch address wrong");
  a_err_write: assert property (@(posedge clk) disable iff (!rstn)
    wr_cmpl |=> err_q == $past(req.wdata[19:16])) else $error("error code lost");
  a_start_write: assert property (@(posedge clk) disable iff (!rstn)
    wr_start |=> start_q == $past(req.wdata)) else $error("start address lost");
  a_strap_value: assert property (@(posedge clk) disable iff (!rstn)
    !strap_taken_q && !wr_start |=> start_q == ($past(mode_s2_q) ? HBHR_EXT_START_RST : HBHR_ROM_START_RST))
    else $error("start default wrong");
  a_err_hold: assert property (@(posedge clk) disable iff (!rstn)
    !wr_cmpl |=> err_q == $past(err_q)) else $error("error code changed");
  a_start_hold: assert property (@(posedge clk) disable iff (!rstn)
    strap_taken_q && !wr_start |=> start_q == $past(start_q)) else $error("start address changed");
  a_read_start: assert property (@(posedge clk) disable iff (!rstn)
    req.rd && hit_start |=> rdata == $past(start_q)) else $error("start read wrong");
  a_read_cmpl: assert property (@(posedge clk) disable iff (!rstn)
    req.rd && hit_cmpl |=> rdata[19:16] == $past(err_q) && rdata[0] == $past(done_q))
    else $error("completion read wrong");
  a_read_unmapped: assert property (@(posedge clk) disable iff (!rstn)
    req.rd && !hit_start && !hit_cmpl |=> rdata == 32'h00000000) else $error("unmapped read nonzero");
  a_rvalid_follow: assert property (@(posedge clk) disable iff (!rstn)
    req.rd |=> rvalid) else $error("read not answered");
  a_done_zero_write: assert property (@(posedge clk) disable iff (!rstn)
    wr_cmpl && !req.wdata[0] && !done_q |=> !done_q) else $error("done set by zero");
  a_branch_done: assert property (@(posedge clk) disable iff (!rstn)
    branch_go |-> host_load_done_flag) else $error("branch without done");
  a_rsv_zero: assert property (@(posedge clk) disable iff (!rstn)
    rvalid && $past(hit_cmpl) |-> rdata[31:20] == 12'h000 && rdata[15:1] == 15'h0000)
    else $error("reserved bits nonzero");
endmodule // hbhr_regs

/* dv/hbhr_host_model.sv */
// Purpose: External host model driving register accesses
// Assumes: Requests change at the falling edge
// Notes: Idle address and data show inverted values, not stale ones
`timescale 1ns/10ps
module hbhr_host_model
  import hbhr_pkg::*;
(
  input wire logic clk,
  input wire logic [1:0] op,
  input wire logic [31:0] a,
  input wire logic [31:0] d,
  output hbhr_req_s req
);
  always @(negedge clk) req <= '{op[0], op[1], op ? a : ~a, op ? d : ~d};
endmodule // hbhr_host_model

/* dv/test_host_boot_handshake_registers.sv */
// Purpose: Self-checking bench for the boot handshake registers
// Assumes: Host model issues one access per call
// Notes: Branch pulses are counted, not timed
`timescale 1ns/10ps
module test_host_boot_handshake_registers;
  import hbhr_pkg::*;
  localparam logic [31:0] S = HBHR_START_ADDR_OFS, C = HBHR_BOOT_CMPL_OFS;
  typedef struct {logic [1:0] o; logic [31:0] a, d, e;} hbhr_row_s;
  hbhr_row_s rows[7] = '{'{2, S, 0, HBHR_ROM_START_RST}, '{2, C, 0, 0}, '{1, S, 32'h12345678, 0},
    '{2, S, 0, 32'h12345678}, '{1, C, 32'hfff5fffe, 0}, '{2, C, 0, 32'h00050000}, '{2, C + 4, 0, 0}};
  logic clk = 0, rstn = 0, ext = 0, rvalid, go, done;
  logic [1:0] op = 0;
  logic [31:0] a = 0, d = 0, rdata, fetch;
  int n_errors = 0, total_checks = 0, nb = 0, k;
  hbhr_req_s req;
  always #4 clk = ~clk;
  always @(posedge clk) nb += go;
  hbhr_host_model hbhr_host_model_i(.clk(clk), .op(op), .a(a), .d(d), .req(req));
  hbhr_regs hbhr_regs_i(.clk(clk), .rstn(rstn), .req(req), .rdata(rdata), .rvalid(rvalid),
    .boot_from_ext_mem(ext), .cpu_fetch_addr(fetch), .branch_go(go), .host_load_done_flag(done));
  task chk(string s, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  task acc(logic [1:0] o, logic [31:0] ad, logic [31:0] dd, logic [31:0] e);
    @(negedge clk);
    op <= o;
    a <= ad;
    d <= dd;
    @(negedge clk);
    op <= 0;
    @(negedge clk);
    if (o == 2) begin
      chk("rvalid", 1, rvalid);
      chk("rdata", e, rdata);
    end
  endtask
  task give_verdict;
    if (n_errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    give_verdict;
  end
  initial begin
    repeat (16) @(negedge clk);
    rstn = 1;
    repeat (2) @(negedge clk);
    foreach (rows[i]) acc(rows[i].o, rows[i].a, rows[i].d, rows[i].e);
    k = nb;
    acc(1, C, 1, 0);
    @(negedge clk);
    chk("branch_go", k + 1, nb);
    chk("done", 1, done);
    chk("fetch", 32'h12345400, fetch);
    acc(1, C, 0, 0);
    acc(2, C, 0, 32'h00000001);
    chk("branch_go", k + 1, nb);
    ext = 1;
    rstn = 0;
    repeat (3) @(negedge clk);
    chk("done", 0, done);
    rstn = 1;
    repeat (3) @(negedge clk);
    chk("fetch", HBHR_EXT_START_RST, fetch);
    acc(2, C, 0, 0);
    give_verdict;
  end
endmodule // test_host_boot_handshake_registers
